// ---- core/pmfl_consts.svh ----
/*
 * constants of the power monitor fault-limit block: register offsets,
 * reset values and field positions.
 * assumes inclusion by bare name from the core folder.
 */
`ifndef PMFL_CONSTS_SVH
`define PMFL_CONSTS_SVH

// register byte offsets (word aligned)
`define PMFL_OFS_DEV_CFG   8'h00
`define PMFL_OFS_CONV_CFG  8'h04
`define PMFL_OFS_CUR_LIM   8'h08
`define PMFL_OFS_BUS_LIM   8'h0c
`define PMFL_OFS_PWR_LIM   8'h10
`define PMFL_OFS_CUR_RES   8'h14
`define PMFL_OFS_BUS_RES   8'h18
`define PMFL_OFS_PWR_RES   8'h1c
`define PMFL_OFS_TMP_RES   8'h20
`define PMFL_OFS_CHG_RES   8'h24
`define PMFL_OFS_IRQ_STAT  8'h28
`define PMFL_OFS_IRQ_CLR   8'h2c
`define PMFL_OFS_IRQ_EN    8'h30

// reset values
`define PMFL_RST_DEV_CFG   16'h0000
`define PMFL_RST_CONV_CFG  16'h0007
`define PMFL_RST_CUR_LIM   16'h7fff
`define PMFL_RST_BUS_LIM   16'h7fff
`define PMFL_RST_PWR_LIM   16'hffff
`define PMFL_RST_IRQ_EN    3'h0

// converter configuration fields
`define PMFL_CONV_RUN_BIT  0
`define PMFL_CONV_SEQ_MSB  2
`define PMFL_CONV_SEQ_LSB  1

// alignment shifts of 16-bit limits onto results
`define PMFL_SHIFT_VI      4
`define PMFL_SHIFT_PWR     8

// status bit positions
`define PMFL_EV_CUR        0
`define PMFL_EV_BUS        1
`define PMFL_EV_PWR        2

`endif

// ---- core/pmfl_pkg.sv ----
/*
 * types of the power monitor fault-limit block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package pmfl_pkg;

    // channel in the conversion cycle
    typedef enum logic [1:0]
    {
        PMFL_CH_TEMP,
        PMFL_CH_CUR,
        PMFL_CH_BUS
    } pmfl_chan_t;

    // one completed conversion
    typedef struct packed
    {
        logic        valid;
        pmfl_chan_t  chan;
        logic [19:0] value;
    } pmfl_conv_t;

    // measurement results
    typedef struct packed
    {
        logic [19:0] cur;
        logic [19:0] bus;
        logic [23:0] pwr;
        logic [15:0] tmp;
        logic [19:0] chg;
    } pmfl_res_t;

endpackage : pmfl_pkg

// ---- core/pmfl_sequencer.sv ----
/*
 * converter sequencer: walks temperature, current and bus voltage in turn
 * while enabled, one conversion per slot.
 * assumes the front end delivers raw samples on the core clock.
 */
module pmfl_sequencer
    import pmfl_pkg::*;
#(
    parameter int SLOT_CYCLES = 16
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        run_in,
    input  wire logic [19:0] temp_smp_in,
    input  wire logic [19:0] cur_smp_in,
    input  wire logic [19:0] bus_smp_in,
    output pmfl_conv_t       conv_out
);

    logic [$clog2(SLOT_CYCLES)-1:0] slot_cnt_ff;
    pmfl_chan_t                     chan_ff;
    logic                           done;

    assign done = (slot_cnt_ff == ($clog2(SLOT_CYCLES))'(SLOT_CYCLES - 1));

    // slot timer
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            slot_cnt_ff <= '0;
        else if (!run_in || done)
            slot_cnt_ff <= '0;
        else
            slot_cnt_ff <= slot_cnt_ff + 1'b1;
    end

    // channel rotation, temperature then current then bus voltage
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            chan_ff <= PMFL_CH_TEMP;
        else if (run_in && done)
        begin
            unique case (chan_ff)
                PMFL_CH_TEMP: chan_ff <= PMFL_CH_CUR;
                PMFL_CH_CUR:  chan_ff <= PMFL_CH_BUS;
                default:      chan_ff <= PMFL_CH_TEMP;
            endcase
        end
    end

    // conversion result register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            conv_out <= '0;
        else
        begin
            conv_out.valid <= run_in && done;
            conv_out.chan  <= chan_ff;
            unique case (chan_ff)
                PMFL_CH_TEMP: conv_out.value <= temp_smp_in;
                PMFL_CH_CUR:  conv_out.value <= cur_smp_in;
                default:      conv_out.value <= bus_smp_in;
            endcase
        end
    end

endmodule : pmfl_sequencer

// ---- core/pmfl_top.sv ----
/*
 * fault-limit register bank of a digital current and power monitor:
 * wishbone slave, limits, result formats, comparison and interrupt.
 * assumes raw samples on the core clock and one wishbone master.
 */
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
// Overview of operation
// - after reset the converter runs by itself through temperature, current and bus voltage.
// - every power-up loads both configuration registers with their reset values.
// - the 16-bit current and bus limits align with bits 19:4 of the 20-bit results.
// - the 16-bit power limit aligns with bits 23:8 of the 24-bit power result.
// - the current limit register written by the host is the current fault level.
// - the bus voltage result is compared with the bus overvoltage limit register.
// - every power-up returns all limit registers to their defaults.
// - current, bus voltage, charge and temperature read as two's complement values.
`include "pmfl_consts.svh"

module pmfl_top
    import pmfl_pkg::*;
#(
    parameter int SLOT_CYCLES = 16
)
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic [19:0] TEMP_SMP_IN,
    input  wire logic [19:0] CUR_SMP_IN,
    input  wire logic [19:0] BUS_SMP_IN,
    output logic             IRQ_OUT
);

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] dev_cfg_ff;
    logic [15:0] conv_cfg_ff;
    logic [15:0] current_over_limit_threshold_ff;
    logic [15:0] bus_overvoltage_threshold_ff;
    logic [15:0] pwr_lim_ff;
    pmfl_res_t   res_ff;
    logic [2:0]  irq_stat_ff;
    logic [2:0]  irq_en_ff;
    logic        ack_ff;
    logic [31:0] nxt_dat;
    logic        wr_stb;
    logic [2:0]  ev;
    logic [2:0]  clr;
    pmfl_conv_t  conv;
    logic [47:0] pwr_prod;
    logic [19:0] cur_mag;

    // lane-merge of a 16-bit register with the bus data
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        merge16 = old_v;
        if (sel[0])
            merge16[7:0] = dat[7:0];
        if (sel[1])
            merge16[15:8] = dat[15:8];
    endfunction : merge16

    // signed compare of result against limit shifted up
    function automatic logic over_lim(input logic [23:0] res,
                                      input logic [15:0] lim,
                                      input int          shift);
        logic signed [24:0] r;
        logic signed [24:0] l;
        r = {res[23], res};
        l = 25'(signed'(lim)) <<< shift;
        over_lim = (r > l);
    endfunction : over_lim

    // ****************************************
    // wishbone slave
    // ****************************************
    assign wr_stb = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !ack_ff;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            ack_ff <= 1'b0;
        else
            ack_ff <= WB_CYC_IN && WB_STB_IN && !ack_ff;
    end
    assign WB_ACK_OUT = ack_ff;

    // read mux, results sign-extended to 32 bits, power result zero-extended
    always_comb
    begin
        nxt_dat = 32'h0000_0000;
        unique case (WB_ADR_IN)
            `PMFL_OFS_DEV_CFG:  nxt_dat = {16'h0000, dev_cfg_ff};
            `PMFL_OFS_CONV_CFG: nxt_dat = {16'h0000, conv_cfg_ff};
            `PMFL_OFS_CUR_LIM:  nxt_dat = {16'h0000, current_over_limit_threshold_ff};
            `PMFL_OFS_BUS_LIM:  nxt_dat = {16'h0000, bus_overvoltage_threshold_ff};
            `PMFL_OFS_PWR_LIM:  nxt_dat = {16'h0000, pwr_lim_ff};
            `PMFL_OFS_CUR_RES:  nxt_dat = 32'(signed'(res_ff.cur));
            `PMFL_OFS_BUS_RES:  nxt_dat = 32'(signed'(res_ff.bus));
            `PMFL_OFS_PWR_RES:  nxt_dat = {8'h00, res_ff.pwr};
            `PMFL_OFS_TMP_RES:  nxt_dat = 32'(signed'(res_ff.tmp));
            `PMFL_OFS_CHG_RES:  nxt_dat = 32'(signed'(res_ff.chg));
            `PMFL_OFS_IRQ_STAT: nxt_dat = {29'h0, irq_stat_ff};
            `PMFL_OFS_IRQ_EN:   nxt_dat = {29'h0, irq_en_ff};
            default:            nxt_dat = 32'h0000_0000;
        endcase
    end

    // read data registered with the ack
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            WB_DAT_OUT <= 32'h0000_0000;
        else if (WB_CYC_IN && WB_STB_IN && !ack_ff)
            WB_DAT_OUT <= nxt_dat;
    end

    // configuration registers, reset to defaults at power-up
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            dev_cfg_ff  <= `PMFL_RST_DEV_CFG;
            conv_cfg_ff <= `PMFL_RST_CONV_CFG;
        end
        else if (wr_stb && WB_ADR_IN == `PMFL_OFS_DEV_CFG)
            dev_cfg_ff <= merge16(dev_cfg_ff, WB_DAT_IN, WB_SEL_IN);
        else if (wr_stb && WB_ADR_IN == `PMFL_OFS_CONV_CFG)
            conv_cfg_ff <= merge16(conv_cfg_ff, WB_DAT_IN, WB_SEL_IN);
    end

    // limit registers, reset to defaults at power-up
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            current_over_limit_threshold_ff <= `PMFL_RST_CUR_LIM;
            bus_overvoltage_threshold_ff    <= `PMFL_RST_BUS_LIM;
            pwr_lim_ff                      <= `PMFL_RST_PWR_LIM;
        end
        else if (wr_stb)
        begin
            if (WB_ADR_IN == `PMFL_OFS_CUR_LIM)
                current_over_limit_threshold_ff <=
                    merge16(current_over_limit_threshold_ff, WB_DAT_IN, WB_SEL_IN);
            if (WB_ADR_IN == `PMFL_OFS_BUS_LIM)
                bus_overvoltage_threshold_ff <=
                    merge16(bus_overvoltage_threshold_ff, WB_DAT_IN, WB_SEL_IN);
            if (WB_ADR_IN == `PMFL_OFS_PWR_LIM)
                pwr_lim_ff <= merge16(pwr_lim_ff, WB_DAT_IN, WB_SEL_IN);
        end
    end

    // ****************************************
    // conversion and results
    // ****************************************
    pmfl_sequencer #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_seq (
        .clk_in      (CORE_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .run_in      (conv_cfg_ff[`PMFL_CONV_RUN_BIT]),
        .temp_smp_in (TEMP_SMP_IN),
        .cur_smp_in  (CUR_SMP_IN),
        .bus_smp_in  (BUS_SMP_IN),
        .conv_out    (conv)
    );

    // power is current magnitude times the bus value being converted, upper bits kept;
    // the magnitude is taken at 20 bits so a negative current never wraps at 48 bits,
    // and the bus value of this conversion is used so power never pairs with a stale bus
    assign cur_mag  = res_ff.cur[19] ? 20'(-res_ff.cur) : res_ff.cur;
    assign pwr_prod = 48'(cur_mag) * 48'(conv.value);

    // result capture, charge follows each current update and power each bus update
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            res_ff <= '0;
        else if (conv.valid)
        begin
            unique case (conv.chan)
                PMFL_CH_TEMP: res_ff.tmp <= conv.value[15:0];
                PMFL_CH_CUR:
                begin
                    res_ff.cur <= conv.value;
                    res_ff.chg <= res_ff.chg + conv.value;
                end
                default:
                begin
                    res_ff.bus <= conv.value;
                    res_ff.pwr <= pwr_prod[39:16];
                end
            endcase
        end
    end

    // ****************************************
    // fault detection and interrupt
    // ****************************************
    always_comb
    begin
        ev = 3'h0;
        if (conv.valid && conv.chan == PMFL_CH_CUR)
            ev[`PMFL_EV_CUR] = over_lim({{4{conv.value[19]}}, conv.value},
                                        current_over_limit_threshold_ff,
                                        `PMFL_SHIFT_VI);
        if (conv.valid && conv.chan == PMFL_CH_BUS)
        begin
            ev[`PMFL_EV_BUS] = over_lim({{4{conv.value[19]}}, conv.value},
                                        bus_overvoltage_threshold_ff,
                                        `PMFL_SHIFT_VI);
            ev[`PMFL_EV_PWR] = ({1'b0, pwr_prod[39:16]} >
                                (25'(pwr_lim_ff) << `PMFL_SHIFT_PWR));
        end
    end

    assign clr = (wr_stb && WB_ADR_IN == `PMFL_OFS_IRQ_CLR) ? WB_DAT_IN[2:0] : 3'h0;

    // sticky status, a new event wins over a clear
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            irq_stat_ff <= 3'h0;
        else
            irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
    end

    // interrupt enable
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            irq_en_ff <= `PMFL_RST_IRQ_EN;
        else if (wr_stb && WB_ADR_IN == `PMFL_OFS_IRQ_EN && WB_SEL_IN[0])
            irq_en_ff <= WB_DAT_IN[2:0];
    end

    assign IRQ_OUT = |(irq_stat_ff & irq_en_ff);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_cur_fault_set: assert property (
        ev[`PMFL_EV_CUR] |=> irq_stat_ff[`PMFL_EV_CUR])
        else $error("current fault not latched");
    a_cur_fault_cause: assert property (
        $rose(irq_stat_ff[`PMFL_EV_CUR]) |-> $past(conv.valid) &&
        $past(conv.chan) == PMFL_CH_CUR &&
        $signed($past(conv.value)) > ($signed({4'h0, $past(current_over_limit_threshold_ff)}) <<< 4)
        || $past(current_over_limit_threshold_ff[15]))
        else $error("current fault without cause");
    a_bus_fault_cmp: assert property (
        conv.valid && conv.chan == PMFL_CH_BUS && !conv.value[19] && !bus_overvoltage_threshold_ff[15]
        && conv.value > {bus_overvoltage_threshold_ff, 4'h0} |=> irq_stat_ff[`PMFL_EV_BUS])
        else $error("bus overvoltage missed");
    a_pwr_fault_cmp: assert property (
        ev[`PMFL_EV_PWR] |=> irq_stat_ff[`PMFL_EV_PWR]
        && res_ff.pwr > {$past(pwr_lim_ff), 8'h00})
        else $error("power fault below limit");
    a_lim_write: assert property (
        wr_stb && WB_ADR_IN == `PMFL_OFS_CUR_LIM && WB_SEL_IN[1:0] == 2'h3
        |=> current_over_limit_threshold_ff == $past(WB_DAT_IN[15:0]))
        else $error("current limit write lost");
    a_run_sequence: assert property (
        conv.valid && conv.chan == PMFL_CH_TEMP && conv_cfg_ff[`PMFL_CONV_RUN_BIT]
        |-> ##[1:SLOT_CYCLES] conv.valid && conv.chan == PMFL_CH_CUR)
        else $error("sequence stalled");
    a_reset_cfg: assert property (
        $rose(RST_N_IN) |-> conv_cfg_ff == `PMFL_RST_CONV_CFG)
        else $error("config not at reset value");
    a_reset_lim: assert property (
        $rose(RST_N_IN) |-> bus_overvoltage_threshold_ff == `PMFL_RST_BUS_LIM)
        else $error("limit not at reset value");
    a_sign_read: assert property (
        ack_ff && $past(WB_ADR_IN) == `PMFL_OFS_CUR_RES && !$past(WB_WE_IN)
        && $past(res_ff.cur[19]) |-> WB_DAT_OUT[31])
        else $error("negative current read unsigned");
    a_irq_level: assert property (
        irq_stat_ff[0] && irq_en_ff[0] |-> IRQ_OUT)
        else $error("irq not raised");

    c_cur_fault: cover property (ev[`PMFL_EV_CUR]);
    c_bus_fault: cover property (ev[`PMFL_EV_BUS]);
    c_pwr_fault: cover property (ev[`PMFL_EV_PWR]);
    c_clear_irq: cover property (IRQ_OUT ##1 !IRQ_OUT);

endmodule : pmfl_top

// ---- verification/pmfl_host_model.sv ----
/*
 * host controller model: a classic single-cycle wishbone master that the
 * bench calls through its tasks to reach the fault-limit register bank.
 * assumes one slave on the same clock and a watchdog in the bench.
 */
`include "pmfl_consts.svh"

module pmfl_host_model
(
    input  wire logic        clk_in,
    input  wire logic [31:0] dat_in,
    input  wire logic        ack_in,
    output logic             cyc_out,
    output logic             stb_out,
    output logic             we_out,
    output logic [7:0]       adr_out,
    output logic [3:0]       sel_out,
    output logic [31:0]      dat_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus from time zero
    initial
    begin
        cyc_out = 1'b0;
        stb_out = 1'b0;
        we_out  = 1'b0;
        adr_out = 8'h00;
        sel_out = 4'h0;
        dat_out = 32'h0;
    end

    // one transfer: request held until ack is sampled high, then released
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] q);
        @(posedge clk_in);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out  <= we;
        adr_out <= adr;
        sel_out <= 4'h3;   // 16-bit registers sit in lanes 0 and 1
        dat_out <= dat;
        do
            @(posedge clk_in);
        while (ack_in !== 1'b1);
        q = dat_in;
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
    endtask : xfer

    // physical value of a raw result: raw count times its fixed weight
    function automatic longint scale(input logic [31:0] raw, input int weight);
        return longint'(signed'(raw)) * weight;
    endfunction : scale

    // rewrite both configuration registers after a power cycle
    task automatic reconfigure(input logic [15:0] dev, input logic [15:0] conv);
        logic [31:0] q;
        xfer(1'b1, `PMFL_OFS_DEV_CFG, {16'h0, dev}, q);
        xfer(1'b1, `PMFL_OFS_CONV_CFG, {16'h0, conv}, q);
    endtask : reconfigure
endmodule : pmfl_host_model

// ---- verification/pmfl_tb_top.sv ----
/*
 * self-checking bench of the fault-limit register bank: integer model of
 * limits, sticky status and results compared with the design's reads.
 * assumes the host model file and the core package and header.
 */
`include "pmfl_consts.svh"
`define PMFL_CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module pmfl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pmfl_pkg::*;

    localparam int SLOT   = 8;
    localparam int SETTLE = 4 * SLOT + 4;
    localparam logic [7:0]  DEF_OFS [8] = '{`PMFL_OFS_DEV_CFG, `PMFL_OFS_CONV_CFG,
        `PMFL_OFS_CUR_LIM, `PMFL_OFS_BUS_LIM, `PMFL_OFS_PWR_LIM, `PMFL_OFS_IRQ_STAT,
        `PMFL_OFS_IRQ_EN, 8'h40};
    localparam logic [31:0] DEF_VAL [8] = '{32'(`PMFL_RST_DEV_CFG), 32'(`PMFL_RST_CONV_CFG),
        32'(`PMFL_RST_CUR_LIM), 32'(`PMFL_RST_BUS_LIM), 32'(`PMFL_RST_PWR_LIM), 32'h0,
        32'(`PMFL_RST_IRQ_EN), 32'h0};

    logic        clk, rst_n, cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rnd, q;
    logic [19:0] tmp_smp, cur_smp, bus_smp;
    logic [2:0]  mdl_stat, mdl_en;
    int          err_count, n_checks, cur_v, bus_v, lim_cur, lim_bus, lim_pwr;

    // ************************************************************
    // clock, design and host
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    pmfl_top #(.SLOT_CYCLES(SLOT)) u_pmfl_top (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .TEMP_SMP_IN(tmp_smp),
        .CUR_SMP_IN(cur_smp), .BUS_SMP_IN(bus_smp), .IRQ_OUT(irq));

    pmfl_host_model u_pmfl_host_model (.clk_in(clk), .dat_in(rdat), .ack_in(ack),
        .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel),
        .dat_out(wdat));

    // ************************************************************
    // model and helpers
    // ************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // power result: magnitude of current times bus, bits 39:16
    function automatic longint pwr_of(input int c, input int b);
        longint a;
        a = (c < 0) ? -c : c;
        return ((a * b) >>> 16) & 64'hffffff;
    endfunction : pwr_of

    // fault events that the current samples raise against the limits
    function automatic logic [2:0] events();
        return {pwr_of(cur_v, bus_v) > (longint'(lim_pwr) << 8),
                bus_v > lim_bus * 16, cur_v > lim_cur * 16};
    endfunction : events

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_pmfl_host_model.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        u_pmfl_host_model.xfer(1'b0, a, 32'h0, q);
        `PMFL_CHK(q, exp)
    endtask : rd_chk

    task automatic set_samples(input int c, input int b);
        @(posedge clk);
        cur_smp <= c[19:0];
        bus_smp <= b[19:0];
        cur_v = c;
        bus_v = b;
    endtask : set_samples

    // let every channel convert at least once, then fold in the events
    task automatic settle();
        repeat (SETTLE) @(posedge clk);
        mdl_stat |= events();
    endtask : settle

    task automatic check_all();
        rd_chk(`PMFL_OFS_IRQ_STAT, {29'h0, mdl_stat});
        rd_chk(`PMFL_OFS_CUR_RES, 32'(cur_v));
        `PMFL_CHK(u_pmfl_host_model.scale(q, 150), longint'(cur_v) * 150)
        rd_chk(`PMFL_OFS_TMP_RES, 32'hffff_f580);
        rd_chk(`PMFL_OFS_BUS_RES, 32'(bus_v));
        rd_chk(`PMFL_OFS_PWR_RES, 32'(pwr_of(cur_v, bus_v)));
        `PMFL_CHK(irq, |(mdl_stat & mdl_en))
    endtask : check_all

    task automatic check_defaults();
        for (int i = 0; i < 8; i++)
            rd_chk(DEF_OFS[i], DEF_VAL[i]);
    endtask : check_defaults

    task automatic set_limits(input int c, input int b, input int p);
        lim_cur = c;
        lim_bus = b;
        lim_pwr = p;
        wr(`PMFL_OFS_CUR_LIM, 32'(c));
        wr(`PMFL_OFS_BUS_LIM, 32'(b));
        wr(`PMFL_OFS_PWR_LIM, 32'(p));
    endtask : set_limits

    task report_and_stop();
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        rst_n = 1'b0;
        tmp_smp = 20'hff580;   // negative in the 16 bits that temperature keeps
        cur_smp = 20'h0;
        bus_smp = 20'h0;
        cur_v = 0;
        bus_v = 0;
        rnd = 32'h461c;
        mdl_stat = 3'h0;
        mdl_en = 3'h0;
        lim_cur = 32'h7fff;
        lim_bus = 32'h7fff;
        lim_pwr = 32'hffff;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        check_defaults();
        // current and bus limit registers hold what the host writes; the hole at 8'h40 ignores writes
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr_next(rnd);
            wr(`PMFL_OFS_CUR_LIM, rnd);
            rd_chk(`PMFL_OFS_CUR_LIM, {16'h0, rnd[15:0]});
            wr(`PMFL_OFS_BUS_LIM, ~rnd);
            rd_chk(`PMFL_OFS_BUS_LIM, {16'h0, ~rnd[15:0]});
        end
        wr(8'h40, 32'hffff);
        rd_chk(8'h40, 32'h0);
        // sane limits first, then drop faults that negative random limits raised
        set_limits(32'h0100, 32'h0200, 32'h0010);
        wr(`PMFL_OFS_IRQ_CLR, 32'h7);
        wr(`PMFL_OFS_IRQ_STAT, 32'h7);
        rd_chk(`PMFL_OFS_IRQ_STAT, 32'h0);
        mdl_en = 3'h7;
        wr(`PMFL_OFS_IRQ_EN, 32'h7);
        // negative current from free-running conversions
        rnd = lfsr_next(rnd);
        set_samples(-(int'(rnd[15:0]) + 1), 32'h100);
        settle();
        check_all();
        // current, then bus voltage, at the limit, then one step above, then cleared
        set_samples(lim_cur * 16, 0);
        settle();
        check_all();
        set_samples(lim_cur * 16 + 1, 0);
        settle();
        check_all();
        set_samples(0, lim_bus * 16);
        settle();
        wr(`PMFL_OFS_IRQ_CLR, 32'h1);
        mdl_stat[0] = 1'b0;
        check_all();
        set_samples(0, lim_bus * 16 + 1);
        settle();
        check_all();
        set_samples(0, 0);
        settle();
        wr(`PMFL_OFS_IRQ_CLR, 32'h2);
        mdl_stat[1] = 1'b0;
        check_all();
        // power at and above its limit, interrupt masked then enabled
        set_limits(32'h7fff, 32'h7fff, 32'h0010);
        mdl_en = 3'h3;
        wr(`PMFL_OFS_IRQ_EN, 32'h3);
        set_samples(32'h10000, 32'h1000);
        settle();
        check_all();
        set_samples(32'h10000, 32'h1001);
        settle();
        check_all();
        mdl_en = 3'h7;
        wr(`PMFL_OFS_IRQ_EN, 32'h7);
        check_all();
        // power cycle in mid-run restores every default
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        check_defaults();
        u_pmfl_host_model.reconfigure(16'h0000, 16'h0007);
        rd_chk(`PMFL_OFS_CONV_CFG, 32'h7);
        report_and_stop();
    end
endmodule : pmfl_tb_top
